/* pkg/fsr_pkg.sv */
package fsr_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_SEARCH_CTRL = 8'h32;
    localparam logic [7:0] ADDR_OUTER = 8'h33;
    localparam logic [7:0] RST_SEARCH_CTRL = 8'h19;
    localparam logic [7:0] RST_OUTER = 8'hf8;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int VS_MANUAL = 7;
    localparam int VS_FREEZE = 6;
    localparam int VS_AVG_HI = 5;
    localparam int VS_AVG_LO = 4;
    localparam int VS_TO_HI = 3;
    localparam int VS_TO_LO = 2;
    localparam int VS_HYST_HI = 1;
    localparam int VS_HYST_LO = 0;
    localparam int OD_DEINTERLEAVE = 7;
    localparam int OD_SYNCHRO = 6;
    localparam int OD_CORRECTION = 5;
    localparam int OD_DESCRAMBLE = 4;
    localparam int OD_WRITE_MARK = 3;
    localparam int OD_BLOCK_SYNC = 2;
    localparam int OD_CLK_POL = 1;
    localparam int OD_PARITY_GATE = 0;
    localparam int MARK_BIT = 7;

    // ----------------------------------------
    // Counts and values
    // ----------------------------------------
    localparam logic [7:0] TIMEOUT_BASE = 8'h10;
    localparam logic [7:0] HYST_BASE = 8'h10;
    localparam logic [7:0] BLOCK_LEN_MAIN = 8'hcc;
    localparam logic [7:0] BLOCK_LEN_ALT = 8'h93;
    localparam logic [7:0] SYNC_BYTE = 8'h47;

    typedef enum logic [2:0] {
        FSR_IDLE = 3'b001,
        FSR_HUNT = 3'b010,
        FSR_LOCK = 3'b100
    } fsr_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic first;
        logic parity;
        logic uncorrectable;
    } fsr_byte_t;

    typedef struct packed {
        logic [7:0] data;
        logic err;
        logic gate;
    } fsr_out_t;

endpackage

/* core/fsr_framer.sv */
// Overview of operation
// - Search bit clear auto, set manual
// - Averaging field picks rate-error bit count
// - Time-out field sets interval between automatic search steps
// - Hysteresis field caps sync counter in blocks
// - Deinterleaver enable selects deinterleave or pass
// - Synchro disabled stops search, holds phase
// - Correction off: no correction, error inactive
// - Descrambler enable selects descramble or bypass
// - Mark MSB after sync on uncorrectable, main standard only
// - Block sync forces first byte 0x47
// - Polarity bit picks output clock edge
// - Parity gating nulls data, error on parity
// - Gated parallel clock low; serial runs
// - Ungated: continuous clock, parity bytes sent
`timescale 1ns/1ns
module fsr_framer #(
    parameter logic [10:0] PERIOD_BITS = 11'h400,
    parameter logic [17:0] AVG_BASE_BITS = 18'h00400
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic link_clk,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    input wire logic alt_standard,
    input wire logic serial_mode,
    input wire logic vit_bit_valid,
    input wire logic sync_word_seen,
    input wire logic manual_step,
    input wire fsr_pkg::fsr_byte_t byte_in,
    input wire logic byte_in_valid,
    output logic byte_in_ready,
    output logic search_step,
    output logic sync_locked,
    output logic rate_window_done,
    output logic byte_phase_hold,
    output logic deinterleave_en,
    output logic correction_en,
    output logic descramble_en,
    output logic [7:0] out_data,
    output logic out_err,
    output logic out_valid,
    output logic out_clk
);
    import fsr_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] search_ctrl;
    logic [7:0] outer;
    wire wr_vs = reg_wr && reg_addr == ADDR_SEARCH_CTRL;
    wire wr_od = reg_wr && reg_addr == ADDR_OUTER;
    wire [7:0] next_rdata = reg_addr == ADDR_SEARCH_CTRL ? search_ctrl :
                            reg_addr == ADDR_OUTER ? outer : 8'h00;
    wire manual = search_ctrl[VS_MANUAL];
    wire freeze = search_ctrl[VS_FREEZE];
    wire [1:0] avg_sel = search_ctrl[VS_AVG_HI:VS_AVG_LO];
    wire [1:0] to_sel = search_ctrl[VS_TO_HI:VS_TO_LO];
    wire [1:0] hyst_sel = search_ctrl[VS_HYST_HI:VS_HYST_LO];
    wire synchro_en = outer[OD_SYNCHRO];
    wire corr_on = outer[OD_CORRECTION];
    wire write_mark = outer[OD_WRITE_MARK];
    wire block_sync_force = outer[OD_BLOCK_SYNC];
    wire parity_gating = outer[OD_PARITY_GATE];

    always_ff @(posedge clock) begin
        if (!nrst) begin
            search_ctrl <= RST_SEARCH_CTRL;
            outer <= RST_OUTER;
            reg_rdata <= 8'h00;
        end else begin
            if (wr_vs) search_ctrl <= reg_wdata;
            if (wr_od) outer <= reg_wdata;
            reg_rdata <= next_rdata;
        end
    end

    // Enables go straight to the datapath stages
    assign deinterleave_en = outer[OD_DEINTERLEAVE];
    assign correction_en = outer[OD_CORRECTION];
    assign descramble_en = outer[OD_DESCRAMBLE];

    // ----------------------------------------
    // Rate-error averaging window
    // ----------------------------------------
    logic [17:0] avg_cnt;
    wire [17:0] avg_limit = AVG_BASE_BITS << {avg_sel, 1'b0};
    wire avg_hit = vit_bit_valid && avg_cnt == avg_limit - 18'h00001;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            avg_cnt <= 18'h00000;
            rate_window_done <= 1'b0;
        end else begin
            if (vit_bit_valid) avg_cnt <= avg_hit ? 18'h00000 : avg_cnt + 1'b1;
            rate_window_done <= avg_hit;
        end
    end

    // ----------------------------------------
    // Block framing and sync hysteresis
    // ----------------------------------------
    logic [7:0] blk_cnt;
    logic sync_in_blk;
    logic [7:0] sync_cnt;
    wire accept = byte_in_valid && byte_in_ready;
    wire [7:0] blk_len = alt_standard ? BLOCK_LEN_ALT : BLOCK_LEN_MAIN;
    wire blk_end = accept && blk_cnt == blk_len - 8'h01;
    wire [7:0] hyst_max = HYST_BASE << hyst_sel;
    wire blk_had_sync = sync_in_blk || sync_word_seen;
    // A sync in the closing cycle still counts for that block
    wire next_sync_in_blk = !blk_end && blk_had_sync;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            blk_cnt <= 8'h00;
            sync_in_blk <= 1'b0;
            sync_cnt <= 8'h00;
        end else begin
            if (accept) blk_cnt <= blk_end ? 8'h00 : blk_cnt + 8'h01;
            sync_in_blk <= next_sync_in_blk;
            if (!synchro_en) sync_cnt <= 8'h00;
            else if (blk_end && blk_had_sync && sync_cnt < hyst_max)
                sync_cnt <= sync_cnt + 8'h01;
            else if (blk_end && !blk_had_sync && sync_cnt != 8'h00)
                sync_cnt <= sync_cnt - 8'h01;
        end
    end

    // ----------------------------------------
    // Synchro search
    // ----------------------------------------
    fsr_state_t state;
    fsr_state_t next_state;
    logic [10:0] per_cnt;
    logic [7:0] to_cnt;
    wire per_tick = vit_bit_valid && per_cnt == PERIOD_BITS - 11'h001;
    wire [7:0] to_limit = TIMEOUT_BASE << to_sel;
    wire to_hit = per_tick && to_cnt == to_limit - 8'h01;
    wire search_ok = synchro_en && !manual;
    // Manual stepping stays blocked by freeze so a frozen point is kept
    wire step_now = (state == FSR_HUNT && to_hit && !freeze) ||
                    (manual && manual_step && synchro_en && !freeze);

    always_comb begin
        next_state = state;
        unique case (state)
            FSR_IDLE: if (search_ok) next_state = FSR_HUNT;
            FSR_HUNT: begin
                if (!search_ok) next_state = FSR_IDLE;
                else if (sync_cnt == hyst_max) next_state = FSR_LOCK;
            end
            FSR_LOCK: begin
                if (!search_ok) next_state = FSR_IDLE;
                else if (sync_cnt == 8'h00) next_state = FSR_HUNT;
            end
            default: next_state = FSR_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= FSR_IDLE;
            per_cnt <= 11'h000;
            to_cnt <= 8'h00;
            search_step <= 1'b0;
            sync_locked <= 1'b0;
            byte_phase_hold <= 1'b0;
        end else begin
            state <= next_state;
            if (vit_bit_valid) per_cnt <= per_tick ? 11'h000 : per_cnt + 11'h001;
            if (state != FSR_HUNT || step_now) to_cnt <= 8'h00;
            else if (per_tick && !freeze) to_cnt <= to_cnt + 8'h01;
            search_step <= step_now;
            sync_locked <= next_state == FSR_LOCK;
            byte_phase_hold <= !synchro_en;
        end
    end

    // ----------------------------------------
    // Byte formatting, core side
    // ----------------------------------------
    logic prev_first;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic ack_tgl;
    fsr_out_t xfer_word;
    wire uncorr_err = corr_on && byte_in.uncorrectable;
    wire gate_byte = parity_gating && byte_in.parity;
    wire do_mark = write_mark && uncorr_err && !alt_standard &&
                   prev_first;
    wire [7:0] marked = do_mark ? (byte_in.data | 8'h80) : byte_in.data;
    wire [7:0] first_fix = block_sync_force && byte_in.first ?
                           SYNC_BYTE : marked;
    fsr_out_t next_word;
    assign next_word.data = gate_byte ? 8'h00 : first_fix;
    assign next_word.err = uncorr_err && !gate_byte;
    assign next_word.gate = gate_byte;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            prev_first <= 1'b0;
            req_tgl <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            xfer_word <= '0;
            byte_in_ready <= 1'b0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            if (accept) begin
                prev_first <= byte_in.first;
                xfer_word <= next_word;
                req_tgl <= !req_tgl;
            end
            // One word in flight; the link pace stalls the source
            byte_in_ready <= !accept && ack_s2 == req_tgl;
        end
    end

    // ----------------------------------------
    // Link side output stage
    // ----------------------------------------
    logic lrst_s1;
    logic lrst_s2;
    logic req_s1;
    logic req_s2;
    logic pol_s1;
    logic pol_s2;
    logic ser_s1;
    logic ser_s2;
    logic ph;
    logic cur_gate;
    wire upd = !ph;
    wire have_word = req_s2 != ack_tgl;
    wire next_gate = upd ? (have_word && xfer_word.gate) : cur_gate;
    wire clk_hold = next_gate && !ser_s2;
    wire next_out_clk = clk_hold ? 1'b0 : (pol_s2 ? ph : !ph);

    always_ff @(posedge link_clk) begin
        lrst_s1 <= nrst;
        lrst_s2 <= lrst_s1;
        req_s1 <= req_tgl;
        req_s2 <= req_s1;
        pol_s1 <= outer[OD_CLK_POL];
        pol_s2 <= pol_s1;
        ser_s1 <= serial_mode;
        ser_s2 <= ser_s1;
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_s2) begin
            ack_tgl <= 1'b0;
            ph <= 1'b0;
            cur_gate <= 1'b0;
            out_data <= 8'h00;
            out_err <= 1'b0;
            out_valid <= 1'b0;
            out_clk <= 1'b0;
        end else begin
            ph <= !ph;
            out_clk <= next_out_clk;
            cur_gate <= next_gate;
            if (upd) begin
                // Data moves with the edge opposite the sampling edge
                out_data <= have_word ? xfer_word.data : 8'h00;
                out_err <= have_word && xfer_word.err;
                out_valid <= have_word;
                if (have_word) ack_tgl <= req_s2;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence auto_timeout_s;
        !manual && per_tick && to_cnt == to_limit - 8'h01;
    endsequence

    step_sync_a: assert property (@(posedge clock) disable iff (!nrst)
        search_step |-> $past(synchro_en))
        else $error("search step with synchro disabled");
    manual_step_a: assert property (@(posedge clock) disable iff (!nrst)
        search_step && $past(manual) |-> $past(manual_step))
        else $error("manual mode stepped on its own");
    timeout_len_a: assert property (@(posedge clock) disable iff (!nrst)
        search_step && !$past(manual) |-> $past(to_hit))
        else $error("auto step before time-out");
    freeze_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        freeze && state == FSR_HUNT ##0 auto_timeout_s |=> !search_step)
        else $error("frozen search stepped");
    avg_window_a: assert property (@(posedge clock) disable iff (!nrst)
        rate_window_done |-> $past(avg_cnt) == $past(avg_limit) - 18'h00001)
        else $error("averaging window length wrong");
    lock_max_a: assert property (@(posedge clock) disable iff (!nrst)
        state == FSR_HUNT && search_ok && sync_cnt == hyst_max
        |=> state == FSR_LOCK ##1 sync_locked || state != FSR_LOCK)
        else $error("lock not taken at hysteresis max");
    force_sync_a: assert property (@(posedge clock) disable iff (!nrst)
        accept && byte_in.first && block_sync_force && !gate_byte
        |=> xfer_word.data == SYNC_BYTE)
        else $error("first byte not forced");
    err_off_a: assert property (@(posedge clock) disable iff (!nrst)
        accept && !corr_on |=> !xfer_word.err)
        else $error("error set with correction off");
    parity_null_a: assert property (@(posedge clock) disable iff (!nrst)
        accept && parity_gating && byte_in.parity
        |=> xfer_word.data == 8'h00 && !xfer_word.err)
        else $error("parity byte not nulled");
    mark_msb_a: assert property (@(posedge clock) disable iff (!nrst)
        accept && do_mark && !gate_byte && !byte_in.first
        |=> xfer_word.data[MARK_BIT])
        else $error("uncorrectable mark missing");
    gate_low_a: assert property (@(posedge link_clk) disable iff (!lrst_s2)
        cur_gate && !ser_s2 |-> !out_clk)
        else $error("clock ran in gated parity byte");
    edge_pol_a: assert property (@(posedge link_clk) disable iff (!lrst_s2)
        $changed(out_data) && !cur_gate && $stable(pol_s2)
        |-> out_clk == !pol_s2)
        else $error("data moved on wrong clock edge");
    // Hold flag lags the enable by one cycle
    phase_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        !synchro_en |=> byte_phase_hold)
        else $error("byte phase not held");
    alt_nomark_a: assert property (@(posedge clock) disable iff (!nrst)
        accept && alt_standard && !byte_in.first && !gate_byte
        |=> xfer_word.data == $past(byte_in.data))
        else $error("byte marked in alternative standard");
    idle_null_a: assert property (@(posedge link_clk) disable iff (!lrst_s2)
        upd && !have_word |=> !out_valid && out_data == 8'h00)
        else $error("idle link showed data");

endmodule // fsr_framer

/* verification/fsr_demux_model.sv */
`timescale 1ns/1ns
// ------
// Packet demultiplexer front end
// ------
module fsr_demux_model (
    input wire logic out_clk,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_err,
    input wire logic pol
);
    logic [8:0] got_q[$];
    // Sample opposite the launch edge, where data has settled
    always @(negedge out_clk) begin
        if (!pol && out_valid === 1'b1) begin
            got_q.push_back({out_err, out_data});
        end
    end
    always @(posedge out_clk) begin
        if (pol && out_valid === 1'b1) begin
            got_q.push_back({out_err, out_data});
        end
    end
endmodule // fsr_demux_model

/* verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    import fsr_pkg::*;
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic vit_bit_valid = 1'b0;
    logic manual_step = 1'b0;
    logic serial_mode = 1'b0;
    logic byte_in_valid = 1'b0;
    logic pol = 1'b0;
    logic alt = 1'b0;
    fsr_byte_t byte_in = '0;
    logic [7:0] reg_rdata, out_data, v, od, d, e;
    logic byte_in_ready, search_step, sync_locked, rate_window_done;
    logic byte_phase_hold, deinterleave_en, correction_en, descramble_en;
    logic out_err, out_valid, out_clk, u;
    logic [8:0] got;
    logic [8:0] exp_q[$];
    int bad_count = 0;
    int n_tests = 0;
    int k;
    // ------
    // Clocks and instances
    // ------
    always #25 clock = ~clock;
    // An odd 125 period keeps the link unrelated in phase
    always begin
        #63 link_clk = ~link_clk;
        #62 link_clk = ~link_clk;
    end
    fsr_framer #(.PERIOD_BITS(11'h004), .AVG_BASE_BITS(18'h00004)) u_dut (
        .clock(clock), .nrst(nrst), .link_clk(link_clk),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rdata(reg_rdata), .alt_standard(alt),
        .serial_mode(serial_mode), .vit_bit_valid(vit_bit_valid),
        .sync_word_seen(1'b0), .manual_step(manual_step),
        .byte_in(byte_in), .byte_in_valid(byte_in_valid),
        .byte_in_ready(byte_in_ready), .search_step(search_step),
        .sync_locked(sync_locked), .rate_window_done(rate_window_done),
        .byte_phase_hold(byte_phase_hold),
        .deinterleave_en(deinterleave_en), .correction_en(correction_en),
        .descramble_en(descramble_en), .out_data(out_data),
        .out_err(out_err), .out_valid(out_valid), .out_clk(out_clk));
    fsr_demux_model u_dem (.out_clk(out_clk), .out_valid(out_valid),
        .out_data(out_data), .out_err(out_err), .pol(pol));
    // ------
    // Tasks
    // ------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = w;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(negedge clock);
        reg_addr = a;
        @(negedge clock);
        r = reg_rdata;
    endtask
    // Interval between two pulses, counted in core cycles
    task automatic gap(input bit rate, input int exp);
        int n;
        n = 0;
        while ((rate ? rate_window_done : search_step) !== 1'b1 && n < 3000)
        begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        n = 1;
        while ((rate ? rate_window_done : search_step) !== 1'b1 && n < 3000)
        begin
            @(negedge clock);
            n++;
        end
        check(n[15:0], exp[15:0]);
    endtask
    task automatic steps(input int cyc, output int s);
        s = 0;
        repeat (cyc) begin
            s += (search_step === 1'b1);
            @(negedge clock);
        end
    endtask
    task automatic send(input logic [7:0] dv, input logic f, p, uc);
        int n;
        n = 0;
        @(negedge clock);
        byte_in = '{data: dv, first: f, parity: p, uncorrectable: uc};
        byte_in_valid = 1'b1;
        while (byte_in_ready !== 1'b1 && n < 500) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        byte_in_valid = 1'b0;
    endtask
    // ------
    // Main sequence
    // ------
    initial begin
        void'($urandom(32'h337ec7b5));
        repeat (3) @(negedge clock);
        nrst = 1'b1;
        rd(ADDR_SEARCH_CTRL, v);
        check(v, RST_SEARCH_CTRL);
        rd(ADDR_OUTER, v);
        check(v, RST_OUTER);
        wr(8'h34, 8'hff);
        rd(8'h34, v);
        check(v, 8'h00);
        od = 8'($urandom);
        wr(ADDR_SEARCH_CTRL, od);
        rd(ADDR_SEARCH_CTRL, v);
        check(v, od);
        wr(ADDR_OUTER, RST_OUTER);
        vit_bit_valid = 1'b1;
        for (int q = 0; q < 4; q++) begin
            wr(ADDR_SEARCH_CTRL, {2'b00, 2'(q), 2'(q), 2'b00});
            gap(1'b1, 4 << (2 * q));
            gap(1'b0, 64 << q);
        end
        wr(ADDR_SEARCH_CTRL, 8'h40);
        steps(200, k);
        check(k[15:0], 16'h0000);
        wr(ADDR_SEARCH_CTRL, 8'h80);
        steps(200, k);
        check(k[15:0], 16'h0000);
        manual_step = 1'b1;
        @(negedge clock);
        manual_step = 1'b0;
        steps(8, k);
        check(k[15:0], 16'h0001);
        wr(ADDR_SEARCH_CTRL, 8'h00);
        wr(ADDR_OUTER, 8'hb8);
        steps(200, k);
        check(k[15:0], 16'h0000);
        vit_bit_valid = 1'b0;
        for (int c = 0; c < 32; c++) begin
            v = 8'($urandom);
            od = {v[2], v[1], ~c[4], v[0], 1'b1, c[3], c[0], c[1]};
            wr(ADDR_OUTER, od);
            serial_mode = c[2];
            pol = c[0];
            rd(ADDR_OUTER, e);
            check(e, od);
            check({deinterleave_en, correction_en, descramble_en,
                byte_phase_hold}, {od[7], od[5], od[4], ~od[6]});
            u = v[3];
            alt = v[4];
            for (int i = 0; i < 6; i++) begin
                d = 8'($urandom);
                send(d, i == 0, i >= 4, u);
                e = d;
                if (i == 0 && c[3]) e = SYNC_BYTE;
                if (i == 1 && u && od[5] && !alt) e[MARK_BIT] = 1'b1;
                if (i >= 4 && c[1]) e = 8'h00;
                // Gated parallel parity bytes see no sampling clock edge
                if (!(i >= 4 && c[1] && !c[2])) begin
                    exp_q.push_back({u & od[5] & ~(i >= 4 && c[1]), e});
                end
            end
            k = 0;
            while (u_dem.got_q.size() < exp_q.size() && k < 400) begin
                @(negedge clock);
                k++;
            end
            repeat (8) @(negedge clock);
            while (exp_q.size() != 0) begin
                got = (u_dem.got_q.size() != 0) ? u_dem.got_q.pop_front() : 'x;
                check({7'h00, got}, {7'h00, exp_q.pop_front()});
            end
            check(u_dem.got_q.size(), 16'h0000);
            u_dem.got_q.delete();
        end
        complete_run();
    end
    initial begin
        #3000000;
        bad_count++;
        complete_run();
    end
endmodule // tb_top
